/* File: hdl/adcseq_defs.svh */
// adcseq_defs.svh: named constants of the conversion sequencer
`ifndef ADCSEQ_DEFS_SVH
`define ADCSEQ_DEFS_SVH

// ****************************************************************
// clock and word geometry
// ****************************************************************
`define ADCSEQ_SYS_CLK_MHZ    100
`define ADCSEQ_RESULT_BITS    14
`define ADCSEQ_FRAME_BITS     16
`define ADCSEQ_CONV_CYCLES    16
`define ADCSEQ_EDGE_W         5
`define ADCSEQ_DIV_W          4
`define ADCSEQ_HOLD_W         12

// ****************************************************************
// timing, each figure in its own unit and its derived cycle count
// ****************************************************************
`define ADCSEQ_CONV_TYP_NS    1800
`define ADCSEQ_CONV_MAX_NS    2500
`define ADCSEQ_ACQ_MAX_NS     500
`define ADCSEQ_EXT_MIN_KHZ    50
// half period of the internal oscillator, rounded down so 16 cycles stay inside the typ time
`define ADCSEQ_INT_HALF_CYC   ((`ADCSEQ_CONV_TYP_NS * `ADCSEQ_SYS_CLK_MHZ) / (2000 * `ADCSEQ_CONV_CYCLES))
// a level held longer than one period of the slowest external clock means "held high"
`define ADCSEQ_EXT_HOLD_CYC   ((`ADCSEQ_SYS_CLK_MHZ * 1000) / `ADCSEQ_EXT_MIN_KHZ)
`define ADCSEQ_BUF_DEPTH      2

// ****************************************************************
// reset values
// ****************************************************************
`define ADCSEQ_BUSY_N_RST     1'b1
`define ADCSEQ_MIRROR_RST     1'b0
// gate and shutdown synchronisers start at the pins' idle level
`define ADCSEQ_PIN_N_RST      1'b1

`endif

/* File: hdl/adcseq_pkg.sv */
// adcseq_pkg: types and shared functions of the conversion sequencer
`include "adcseq_defs.svh"

package adcseq_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [`ADCSEQ_RESULT_BITS-1:0] adcseq_word_t;
  typedef logic [`ADCSEQ_EDGE_W-1:0]      adcseq_edge_t;

  typedef enum logic [3:0] {
    SQ_IDLE = 4'h1,
    SQ_CONV = 4'h2,
    SQ_PUSH = 4'h4,
    SQ_LOAD = 4'h8
  } adcseq_phase_t;

  // ****************************************************************
  // functions
  // ****************************************************************
  // falling edge between the synchronised level and its previous sample
  function automatic logic adcseq_fall(input logic cur, input logic prev);
    return prev & ~cur;
  endfunction : adcseq_fall

  function automatic logic adcseq_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : adcseq_rise

  // one successive approximation step at conversion clock edge k
  function automatic adcseq_word_t adcseq_sar_step(input adcseq_word_t t,
                                                   input adcseq_edge_t k,
                                                   input logic         keep);
    adcseq_word_t o;
    adcseq_edge_t pos;
    o   = t;
    pos = adcseq_edge_t'(`ADCSEQ_RESULT_BITS + 1) - k;
    if (k == adcseq_edge_t'(1)) begin
      o = '0;
      o[`ADCSEQ_RESULT_BITS-1] = 1'b1;
    end else if (k <= adcseq_edge_t'(`ADCSEQ_RESULT_BITS + 1)) begin
      for (int i = 0; i < `ADCSEQ_RESULT_BITS; i++) begin
        if (adcseq_edge_t'(i) == pos) o[i] = keep;
        if (adcseq_edge_t'(i + 1) == pos) o[i] = 1'b1;
      end
    end
    return o;
  endfunction : adcseq_sar_step

  // offset binary stays plain in unipolar mode, msb flips for two's complement
  function automatic adcseq_word_t adcseq_format(input adcseq_word_t w, input logic bip);
    adcseq_word_t o;
    o = w;
    if (bip) o[`ADCSEQ_RESULT_BITS-1] = ~w[`ADCSEQ_RESULT_BITS-1];
    return o;
  endfunction : adcseq_format

endpackage : adcseq_pkg

/* File: hdl/adcseq_stream_if.sv */
// adcseq_stream_if: valid/ready word channel between sequencer parts
`timescale 1ns/1ps
`default_nettype none

interface adcseq_stream_if #(parameter int W = 14);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : adcseq_stream_if

`default_nettype wire

/* File: hdl/adcseq_buf2.sv */
// adcseq_buf2: small result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module adcseq_buf2 #(
  parameter int W     = 14,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic      clk_i,
  input wire logic      rst_n_i,
  // filling and draining sides
  adcseq_stream_if.snk  in_s,
  adcseq_stream_if.src  out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } adcseq_buf_st_t;

  adcseq_buf_st_t r;
  adcseq_buf_st_t n;
  logic           do_in;
  logic           do_out;

  // full and empty come from the count register only
  assign in_s.ready  = (r.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = (r.cnt != '0);
  assign out_s.data  = r.mem[r.rp];

  // pointer walk and occupancy
  always_comb begin
    n      = r;
    do_in  = in_s.valid & in_s.ready;
    do_out = out_s.valid & out_s.ready;
    if (do_in) begin
      n.mem[r.wp] = in_s.data;
      n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
    end
    if (do_out) n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
    if (do_in && !do_out) n.cnt = r.cnt + (AW+1)'(1);
    if (!do_in && do_out) n.cnt = r.cnt - (AW+1)'(1);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) r <= '0;
    else r <= n;
  end
endmodule : adcseq_buf2

`default_nettype wire

/* File: hdl/adcseq_shifter.sv */
// adcseq_shifter: serial output shift register with zero fill
`timescale 1ns/1ps
`default_nettype none

module adcseq_shifter #(
  parameter int RB = 14,
  parameter int FB = 16
) (
  // clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_n_i,
  // shift control from the sequencer
  input  wire logic     shift_i,
  input  wire logic     gate_n_i,
  // new results
  adcseq_stream_if.snk  load_s,
  // serial data, straight from the register msb
  output logic          dout_o
);
  localparam int CW = $clog2(FB + 1);

  typedef struct packed {
    logic [FB-1:0] sreg;
    logic [CW-1:0] cnt;
  } adcseq_sh_st_t;

  adcseq_sh_st_t r;
  adcseq_sh_st_t n;

  // a word is taken between frames or while the gate is high, so a frame is never torn while the gate is low
  assign load_s.ready = gate_n_i | (r.cnt == '0) | (r.cnt >= CW'(FB));
  assign dout_o       = r.sreg[FB-1];

  // load wins over a shift in the same cycle
  always_comb begin
    n = r;
    if (load_s.valid && load_s.ready) begin
      n.sreg = {load_s.data, {(FB-RB){1'b0}}};
      n.cnt  = '0;
    end else if (shift_i) begin
      n.sreg = {r.sreg[FB-2:0], 1'b0};
      if (r.cnt != CW'(FB)) n.cnt = r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) r <= '0;
    else r <= n;
  end
endmodule : adcseq_shifter

`default_nettype wire

/* File: hdl/adcseq_top.sv */
// adcseq_top: conversion sequencer, clock selection, serial port and power control
// Functional notes
// - falling start edge begins a conversion
// - start edges ignored while converting
// - busy low for whole conversion
// - load shift register, then raise busy
// - read gate low enables output, else tri-state
// - unipolar mode gives plain unsigned binary
// - bipolar mode gives two's complement
// - input held high selects internal oscillator
// - sixteen conversion clock cycles per conversion
// - end of conversion gates external clock
// - mirror clock while gate low, else low
// - internal conversion typically 1.8us, max 2.5us
// - acquisition at most 0.5us between conversions
// - shutdown input low powers down
// - gate low light mode, high deep mode
// - light mode keeps logic and reference powered
// - fourteen bits msb first on shift falls
// - zeros follow the fourteen data bits
// - shift edges ignored while gate high
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_defs.svh"

module adcseq_top
  import adcseq_pkg::*;
(
  // clock and reset
  input  wire logic                           SYS_CLK_I,
  input  wire logic                           NRST_I,
  // conversion control
  input  wire logic                           CONV_START_N_I,
  output logic                                BUSY_N_O,
  // conversion clock
  input  wire logic                           CONV_CLOCK_INPUT_I,
  output logic                                CONV_CLOCK_MIRROR_O,
  // serial port
  input  wire logic                           SCLK_I,
  input  wire logic                           RD_N_I,
  output logic                                DOUT_O,
  output logic                                DOUT_OE_O,
  // supply mode and power
  input  wire logic                           BIPOLAR_I,
  input  wire logic                           POWER_DOWN_N_I,
  output logic                                LIGHT_DOWN_O,
  output logic                                DEEP_DOWN_O,
  // analog side of the approximation logic
  input  wire logic                           COMP_I,
  output logic [`ADCSEQ_RESULT_BITS-1:0]      TRIAL_O,
  output logic                                HOLD_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    // pin synchronisers: s1 feeds only s2, s3 is the previous s2
    logic                       start_s1;
    logic                       start_s2;
    logic                       start_s3;
    logic                       ext_s1;
    logic                       ext_s2;
    logic                       ext_s3;
    logic                       sclk_s1;
    logic                       sclk_s2;
    logic                       sclk_s3;
    logic                       rd_s1;
    logic                       rd_s2;
    logic                       dn_s1;
    logic                       dn_s2;
    logic                       bip_s1;
    logic                       bip_s2;
    logic                       comp_s1;
    logic                       comp_s2;
    // sequencer
    adcseq_phase_t              phase;
    logic                       use_ext;
    logic                       bip_l;
    logic [`ADCSEQ_DIV_W-1:0]   div_cnt;
    logic                       int_lvl;
    adcseq_edge_t               edge_cnt;
    adcseq_word_t               trial;
    logic [`ADCSEQ_HOLD_W-1:0]  hold_cnt;
    adcseq_word_t               push_data;
    logic                       push_valid;
    // registered outputs
    logic                       busy_n;
    logic                       mirror;
    logic                       dout_oe;
    logic                       light;
    logic                       deep;
    logic                       hold;
  } adcseq_top_st_t;

  adcseq_top_st_t r;
  adcseq_top_st_t n;

  // decoded events, taken from synchronised flops, the hold count and the internal divider
  logic start_fall;
  logic ext_rise;
  logic ext_fall;
  logic ext_held;
  logic int_rise;
  logic int_fall;
  logic clk_rise;
  logic clk_fall;
  logic clk_lvl;
  logic shift_pulse;

  // ****************************************************************
  // result path: sequencer -> two-entry buffer -> shift register
  // ****************************************************************
  adcseq_stream_if #(.W(`ADCSEQ_RESULT_BITS)) push_if ();
  adcseq_stream_if #(.W(`ADCSEQ_RESULT_BITS)) pop_if ();

  assign push_if.valid = r.push_valid;
  assign push_if.data  = r.push_data;

  // the buffer lets a finished word wait while a frame is still being shifted
  adcseq_buf2 #(
    .W     (`ADCSEQ_RESULT_BITS),
    .DEPTH (`ADCSEQ_BUF_DEPTH)
  ) u_buf (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (NRST_I),
    .in_s    (push_if),
    .out_s   (pop_if)
  );

  adcseq_shifter #(
    .RB (`ADCSEQ_RESULT_BITS),
    .FB (`ADCSEQ_FRAME_BITS)
  ) u_shift (
    .clk_i    (SYS_CLK_I),
    .rst_n_i  (NRST_I),
    .shift_i  (shift_pulse),
    .gate_n_i (r.rd_s2),
    .load_s   (pop_if),
    .dout_o   (DOUT_O)
  );

  // ****************************************************************
  // edge detection on synchronised pins
  // ****************************************************************
  always_comb begin
    start_fall  = adcseq_fall(r.start_s2, r.start_s3);
    ext_rise    = adcseq_rise(r.ext_s2, r.ext_s3);
    ext_fall    = adcseq_fall(r.ext_s2, r.ext_s3);
    ext_held    = (r.hold_cnt == `ADCSEQ_HOLD_W'(`ADCSEQ_EXT_HOLD_CYC));
    // shift edges only count while the read gate is low
    shift_pulse = adcseq_fall(r.sclk_s2, r.sclk_s3) & ~r.rd_s2;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n        = r;
    int_rise = 1'b0;
    int_fall = 1'b0;

    // two flops on every pin before any logic looks at it
    n.start_s1 = CONV_START_N_I;
    n.start_s2 = r.start_s1;
    n.start_s3 = r.start_s2;
    n.ext_s1   = CONV_CLOCK_INPUT_I;
    n.ext_s2   = r.ext_s1;
    n.ext_s3   = r.ext_s2;
    n.sclk_s1  = SCLK_I;
    n.sclk_s2  = r.sclk_s1;
    n.sclk_s3  = r.sclk_s2;
    n.rd_s1    = RD_N_I;
    n.rd_s2    = r.rd_s1;
    n.dn_s1    = POWER_DOWN_N_I;
    n.dn_s2    = r.dn_s1;
    n.bip_s1   = BIPOLAR_I;
    n.bip_s2   = r.bip_s1;
    n.comp_s1  = COMP_I;
    n.comp_s2  = r.comp_s1;

    // a running external clock keeps restarting this count; saturation means held high
    if (r.ext_s2 && r.ext_s3) begin
      if (!ext_held) n.hold_cnt = r.hold_cnt + `ADCSEQ_HOLD_W'(1);
    end else begin
      n.hold_cnt = '0;
    end

    // internal oscillator: a divider that runs only inside a conversion
    if (r.phase == SQ_CONV && !r.use_ext) begin
      if (r.div_cnt == `ADCSEQ_DIV_W'(`ADCSEQ_INT_HALF_CYC - 1)) begin
        n.div_cnt = '0;
        n.int_lvl = ~r.int_lvl;
        int_rise  = ~r.int_lvl;
        int_fall  = r.int_lvl;
      end else begin
        n.div_cnt = r.div_cnt + `ADCSEQ_DIV_W'(1);
      end
    end

    // selected conversion clock, fixed for the whole conversion
    clk_rise = r.use_ext ? ext_rise : int_rise;
    clk_fall = r.use_ext ? ext_fall : int_fall;
    clk_lvl  = r.use_ext ? r.ext_s2 : n.int_lvl;

    // sequencer
    case (r.phase)
      SQ_IDLE: begin
        // shutdown blocks new conversions; acquisition needs no extra wait here
        if (start_fall && r.dn_s2) begin
          n.phase    = SQ_CONV;
          n.busy_n   = 1'b0;
          n.use_ext  = ~ext_held;
          n.bip_l    = r.bip_s2;
          n.div_cnt  = '0;
          n.int_lvl  = 1'b0;
          n.edge_cnt = '0;
          n.trial    = '0;
          n.hold     = 1'b1;
        end
      end
      SQ_CONV: begin
        // further start edges fall through here unused
        if (clk_rise && r.edge_cnt != adcseq_edge_t'(`ADCSEQ_CONV_CYCLES)) begin
          n.edge_cnt = r.edge_cnt + adcseq_edge_t'(1);
          n.trial    = adcseq_sar_step(r.trial, n.edge_cnt, r.comp_s2);
        end
        // end of conversion after the last cycle; later clock edges are ignored
        if (clk_fall && r.edge_cnt == adcseq_edge_t'(`ADCSEQ_CONV_CYCLES)) begin
          n.phase      = SQ_PUSH;
          n.push_valid = 1'b1;
          n.push_data  = adcseq_format(r.trial, r.bip_l);
          n.hold       = 1'b0;
        end
      end
      SQ_PUSH: begin
        // a full buffer stalls the sequencer here with busy still low
        if (push_if.ready) begin
          n.push_valid = 1'b0;
          n.phase      = SQ_LOAD;
        end
      end
      SQ_LOAD: begin
        // busy rises only once the word sits in the shift register
        if (!pop_if.valid) begin
          n.busy_n = 1'b1;
          n.phase  = SQ_IDLE;
        end
      end
      default: begin
        n.phase  = SQ_IDLE;
        n.busy_n = `ADCSEQ_BUSY_N_RST;
      end
    endcase

    // mirror shows the gated clock only inside a conversion with the gate low
    n.mirror = (n.phase == SQ_CONV) & ~r.rd_s2 & clk_lvl
               & (n.edge_cnt != '0);

    // output buffer follows the read gate
    n.dout_oe = ~r.rd_s2;

    // power modes: the gate picks which one while shut down
    n.light = ~r.dn_s2 & ~r.rd_s2;
    n.deep  = ~r.dn_s2 & r.rd_s2;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      r        <= '0;
      r.phase  <= SQ_IDLE;
      r.busy_n <= `ADCSEQ_BUSY_N_RST;
      r.mirror <= `ADCSEQ_MIRROR_RST;
      // a zero here would enable the output and show light mode right after reset
      r.rd_s1  <= `ADCSEQ_PIN_N_RST;
      r.rd_s2  <= `ADCSEQ_PIN_N_RST;
      r.dn_s1  <= `ADCSEQ_PIN_N_RST;
      r.dn_s2  <= `ADCSEQ_PIN_N_RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // outputs, each straight from a flop
  // ****************************************************************
  assign BUSY_N_O            = r.busy_n;
  assign CONV_CLOCK_MIRROR_O = r.mirror;
  assign DOUT_OE_O           = r.dout_oe;
  assign LIGHT_DOWN_O        = r.light;
  assign DEEP_DOWN_O         = r.deep;
  assign TRIAL_O             = r.trial;
  assign HOLD_O              = r.hold;

endmodule : adcseq_top

`default_nettype wire

/* File: verification/adcseq_props.sv */
// adcseq_props: concurrent checks on the sequencer pins
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_defs.svh"

module adcseq_props (
  // clock and reset
  input wire logic                          SYS_CLK_I,
  input wire logic                          NRST_I,
  // control and power pins
  input wire logic                          CONV_START_N_I,
  input wire logic                          RD_N_I,
  input wire logic                          POWER_DOWN_N_I,
  // observed outputs
  input wire logic                          BUSY_N_O,
  input wire logic                          CONV_CLOCK_MIRROR_O,
  input wire logic                          DOUT_O,
  input wire logic                          DOUT_OE_O,
  input wire logic                          LIGHT_DOWN_O,
  input wire logic                          DEEP_DOWN_O,
  input wire logic [`ADCSEQ_RESULT_BITS-1:0] TRIAL_O,
  input wire logic                          HOLD_O
);
  logic [2:0] age_r;

  // ********************
  // helper logic
  // ********************
  // edges since reset release; the synchronisers hide a start on the first edge only
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);

  // ********************
  // assertions
  // ********************
  chk_oe_gate_on: assert property (!RD_N_I [*5] |-> DOUT_OE_O)
    else $error("output not enabled with gate low");
  chk_oe_gate_off: assert property (RD_N_I [*5] |-> !DOUT_OE_O)
    else $error("output driven with gate high");
  chk_light_mode: assert property ((!POWER_DOWN_N_I && !RD_N_I) [*5] |-> LIGHT_DOWN_O && !DEEP_DOWN_O)
    else $error("light power-down not selected");
  chk_deep_mode: assert property ((!POWER_DOWN_N_I && RD_N_I) [*5] |-> DEEP_DOWN_O && !LIGHT_DOWN_O)
    else $error("deep power-down not selected");
  chk_start_busy: assert property ($fell(CONV_START_N_I) && BUSY_N_O && POWER_DOWN_N_I
    && $past(POWER_DOWN_N_I, 4) && age_r == 3'h7 |-> ##[1:4] !BUSY_N_O)
    else $error("start edge did not begin a conversion");
  chk_hold_busy: assert property (HOLD_O |-> !BUSY_N_O)
    else $error("busy high while converting");
  chk_busy_rise: assert property ($rose(BUSY_N_O) |-> !HOLD_O && !$past(HOLD_O, 2))
    else $error("busy rose before the result was loaded");
  chk_mirror_idle: assert property (!HOLD_O [*2] |-> !CONV_CLOCK_MIRROR_O)
    else $error("clock mirror active outside a conversion");
  chk_mirror_gate: assert property (RD_N_I [*5] |-> !CONV_CLOCK_MIRROR_O)
    else $error("clock mirror active with gate high");
  chk_dout_frozen: assert property ((RD_N_I && BUSY_N_O) [*4] |-> $stable(DOUT_O))
    else $error("serial data moved with gate high");
  chk_trial_first: assert property ($rose(HOLD_O) |-> ##[1:30] TRIAL_O == 14'h2000)
    else $error("first trial word missing");

  // main scenarios seen
  cov_end: cover property ($rose(BUSY_N_O));
  cov_light: cover property (LIGHT_DOWN_O);
  cov_mirror: cover property ($rose(CONV_CLOCK_MIRROR_O));
endmodule : adcseq_props

`default_nettype wire

/* File: verification/adcseq_host_model.sv */
// adcseq_host_model: serial reader on the host side of the link
`timescale 1ns/1ps
`default_nettype none

module adcseq_host_model (
  // link to the sequencer
  output var logic sclk_o,
  output var logic rd_n_o,
  input  wire logic dout_i,
  input  wire logic oe_i
);
  logic last = 1'b0;

  // shift clock stands low between frames, gate starts high
  initial begin
    sclk_o = 1'b0;
    rd_n_o = 1'b1;
  end

  // gate change, then time for the pin to settle inside the device
  task automatic gate(input logic v);
    rd_n_o = v;
    #100;
  endtask : gate

  // n shift clocks of 80 ns; bit taken late in the high phase, where it is settled
  task automatic frame(input int n, output logic [31:0] w);
    logic b;
    w = '0;
    #3;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b1;
      #40;
      b = oe_i ? dout_i : ~last; // a released line shows no stale value
      last = b;
      w = {w[30:0], b};
      sclk_o = 1'b0;
      #40;
    end
  endtask : frame
endmodule : adcseq_host_model

`default_nettype wire

/* File: verification/testbench.sv */
// testbench: directed scenarios for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import adcseq_pkg::*;

  // ********************
  // pins and counters
  // ********************
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        start_n = 1'b1;
  logic        cci = 1'b1;
  logic        ext_run = 1'b0;
  logic        bip = 1'b0;
  logic        pdn = 1'b1;
  logic        comp = 1'b0;
  logic [13:0] vin = 14'h0000;
  logic        mir_q = 1'b0;
  logic        bsy_q = 1'b1;
  logic [31:0] w;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          n_mir = 0;
  int          n_fall = 0;
  wire logic   busy_n, mirror, dout, oe, light, deep, hold, sclk, rd_n;
  wire logic [13:0] trial;

  always #5 clk = ~clk;
  // external conversion clock, 5 MHz, off the system clock phase
  initial begin
    #3;
    forever begin
      #100;
      cci = ext_run ? ~cci : 1'b1;
    end
  end
  // comparator of the analog side: keep the bit while input reaches the trial
  always @(negedge clk) comp <= (vin >= trial);
  // mirror rises and busy falls are counted for the scenarios
  always @(posedge clk) begin
    mir_q <= mirror;
    bsy_q <= busy_n;
    if (mirror && !mir_q) n_mir <= n_mir + 1;
    if (!busy_n && bsy_q) n_fall <= n_fall + 1;
  end

  adcseq_top i_adcseq_top (
    .SYS_CLK_I(clk), .NRST_I(nrst), .CONV_START_N_I(start_n), .BUSY_N_O(busy_n),
    .CONV_CLOCK_INPUT_I(cci), .CONV_CLOCK_MIRROR_O(mirror), .SCLK_I(sclk),
    .RD_N_I(rd_n), .DOUT_O(dout), .DOUT_OE_O(oe), .BIPOLAR_I(bip),
    .POWER_DOWN_N_I(pdn), .LIGHT_DOWN_O(light), .DEEP_DOWN_O(deep),
    .COMP_I(comp), .TRIAL_O(trial), .HOLD_O(hold));
  adcseq_host_model i_adcseq_host_model (
    .sclk_o(sclk), .rd_n_o(rd_n), .dout_i(dout), .oe_i(oe));

  // ********************
  // shared tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // busy level is the end-of-conversion event; a hang closes the run
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy_n !== lvl && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 3000) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: busy wait timed out", $time);
      print_verdict();
    end
  endtask : wait_busy

  // four-cycle start pulse
  task automatic conv();
    @(negedge clk);
    start_n = 1'b0;
    repeat (4) @(negedge clk);
    start_n = 1'b1;
  endtask : conv

  task automatic rd(input int n);
    i_adcseq_host_model.frame(n, w);
  endtask : rd

  // ********************
  // scenarios
  // ********************
  task automatic t_internal();
    time t0;
    i_adcseq_host_model.gate(1'b0);
    vin = 14'h2A5C;
    n_mir = 0;
    n_fall = 0;
    t0 = $time;
    conv();
    repeat (20) @(negedge clk);
    conv(); // a second start inside the conversion must not restart it
    wait_busy(1'b1);
    chk($time - t0 <= 2500, 1'b1);
    chk(n_mir, 16);
    chk(n_fall, 1);
    rd(18);
    chk(w[17:0], {vin, 4'h0});
    $display("test internal clock done");
  endtask : t_internal

  task automatic t_modes();
    for (int i = 0; i < 2; i++) begin
      bip = (i == 0);
      vin = (i == 0) ? 14'h0123 : 14'h3FFF;
      conv();
      wait_busy(1'b1);
      chk(dout, vin[13] ^ bip);
      rd(16);
      chk(w[15:0], {vin ^ {bip, 13'h0}, 2'b00});
    end
    $display("test data formats done");
  endtask : t_modes

  task automatic t_ext();
    ext_run = 1'b1;
    bip = 1'b0;
    vin = 14'h1555;
    repeat (50) @(negedge clk);
    n_mir = 0;
    conv();
    wait_busy(1'b1);
    repeat (200) @(negedge clk);
    chk(n_mir, 16);
    vin = 14'h0AAA;
    // separate shift and conversion clocks on purpose: this model has no clock
    // coupling noise, and the case stresses both synchronisers at once
    fork
      rd(16);
      begin
        conv();
        wait_busy(1'b1);
      end
    join
    chk(w[15:0], {14'h1555, 2'b00});
    rd(16);
    chk(w[15:0], {vin, 2'b00});
    $display("test external clock done");
  endtask : t_ext

  task automatic t_gate();
    i_adcseq_host_model.gate(1'b1);
    chk(oe, 1'b0);
    vin = 14'h0F0F;
    n_mir = 0;
    conv();
    rd(5);
    wait_busy(1'b1);
    chk(n_mir, 0);
    i_adcseq_host_model.gate(1'b0);
    rd(16);
    chk(w[15:0], {vin, 2'b00});
    $display("test read gate done");
  endtask : t_gate

  // reader stalls mid-word, so the next result waits in the buffer
  task automatic t_stall();
    logic [13:0] x;
    x = 14'h3001;
    vin = x;
    conv();
    wait_busy(1'b1);
    rd(5);
    vin = 14'h0456;
    conv();
    repeat (600) @(negedge clk);
    chk(busy_n, 1'b0);
    rd(11);
    chk(w[10:0], {x[8:0], 2'b00});
    wait_busy(1'b1);
    rd(16);
    chk(w[15:0], {vin, 2'b00});
    $display("test stall done");
  endtask : t_stall

  task automatic t_power();
    @(negedge clk);
    pdn = 1'b0;
    repeat (10) @(negedge clk);
    chk({light, deep}, 2'b10);
    i_adcseq_host_model.gate(1'b1);
    chk({light, deep}, 2'b01);
    n_fall = 0;
    conv();
    repeat (50) @(negedge clk);
    chk(n_fall, 0);
    // wake from light mode, never straight from deep, so no reference settling wait
    i_adcseq_host_model.gate(1'b0);
    @(negedge clk);
    pdn = 1'b1;
    repeat (50) @(negedge clk);
    vin = 14'h0777;
    conv();
    wait_busy(1'b1);
    rd(16);
    chk(w[15:0], {vin, 2'b00});
    $display("test power-down done");
  endtask : t_power

  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk({busy_n, mirror, oe}, 3'b100);
    $display("test reset done");
    repeat (2100) @(negedge clk);
    t_internal();
    t_modes();
    t_ext();
    t_gate();
    t_stall();
    t_power();
    print_verdict();
  end
endmodule : testbench

bind adcseq_top adcseq_props i_adcseq_props (
  .SYS_CLK_I, .NRST_I, .CONV_START_N_I, .RD_N_I, .POWER_DOWN_N_I, .BUSY_N_O,
  .CONV_CLOCK_MIRROR_O, .DOUT_O, .DOUT_OE_O, .LIGHT_DOWN_O, .DEEP_DOWN_O,
  .TRIAL_O, .HOLD_O);

`default_nettype wire
